/* File: pct_timer.sv */
`timescale 1ns/10ps
// Behaviour
// - Entering PWM mode from reset, timer or event mode sets timer A request.
// - Clearing the start flag during PWM output stops the counter.
// - Stopping with PWM output high drives it low and sets request.
// - Stopping with PWM output low leaves output and request untouched.
// - Reading timer B while counting in timer or event mode returns the live counter value.
// - A timer B read in the reload cycle returns all ones.
// - A write while halted is what reads return before counting starts, except a timer B write in measurement mode, which is ignored.
// - Changing measurement selection after start sets timer B request.
// - First measurement edge captures an undefined value without a request.
// - Measurement counter may overflow before first edge, setting flag and request.
module pct_timer
	import pct_pkg::*;
(
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic [4:0]  i_addr,
	input  wire logic [31:0] i_wr_data,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	output logic      [31:0] o_rd_data,
	input  wire logic        i_event_a,
	input  wire logic        i_event_b,
	output logic             o_pwm_output_pin,
	output logic             o_irq
);

	logic [1:0]        rst_sync_q;
	logic              rst_n;
	logic [1:0]        ev_meta_q;
	logic [1:0]        ev_sync_q;
	logic [1:0]        ev_prev_q;
	logic [1:0]        ev_rise;
	logic [1:0]        ev_fall;
	logic [1:0]        div_q;
	logic              tick;
	pct_ctrl_t         ctrl_q;
	pct_ctrl_t         new_ctrl;
	logic              wr_ctrl;
	logic              wr_a_cnt;
	logic              wr_b_cnt;
	logic [15:0]       wr_low;
	logic [15:0]       cnt_a_q;
	logic [15:0]       reload_a_q;
	logic [15:0]       high_a_q;
	logic              pwm_q;
	logic              a_pwm_run;
	logic              a_step;
	logic              a_stop;
	logic              a_ev_mode;
	logic              a_ev_stop;
	logic              a_ev_fall;
	logic              a_ev_under;
	logic              pwm_next;
	logic [15:0]       cnt_b_q;
	logic [15:0]       reload_b_q;
	logic              first_q;
	logic              b_meas;
	logic              b_step;
	logic              b_edge;
	logic              b_reload_now;
	logic              b_ev_sel;
	logic              b_ev_edge;
	logic              b_ev_ovf;
	logic [IRQ_W-1:0]  status_q;
	logic [IRQ_W-1:0]  mask_q;
	logic [IRQ_W-1:0]  irq_set;
	logic [IRQ_W-1:0]  irq_clr;
	logic [31:0]       rd_d;
	logic [31:0]       rd_data_q;

	// Reset is released through two flip-flops so that release is clean.
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Event pins are asynchronous; edges are taken only after two stages.
	for (genvar g = 0; g < 2; g++) begin : g_pin
		logic pin_in;
		assign pin_in = (g == 0) ? i_event_a : i_event_b;
		always_ff @(posedge i_clock or negedge rst_n) begin
			if (!rst_n) begin
				ev_meta_q[g] <= 1'b0;
				ev_sync_q[g] <= 1'b0;
				ev_prev_q[g] <= 1'b0;
			end else begin
				ev_meta_q[g] <= pin_in;
				ev_sync_q[g] <= ev_meta_q[g];
				ev_prev_q[g] <= ev_sync_q[g];
			end
		end
		assign ev_rise[g] = ev_sync_q[g] & ~ev_prev_q[g];
		assign ev_fall[g] = ~ev_sync_q[g] & ev_prev_q[g];
	end

	// Internal count source divider.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 2'h0;
		end else if (div_q == DIV_LAST) begin
			div_q <= 2'h0;
		end else begin
			div_q <= div_q + 2'h1;
		end
	end
	assign tick = (div_q == DIV_LAST);

	assign wr_ctrl  = i_wr_en && (i_addr == ADDR_CTRL);
	assign wr_a_cnt = i_wr_en && (i_addr == ADDR_A_CNT);
	assign wr_b_cnt = i_wr_en && (i_addr == ADDR_B_CNT);
	assign wr_low   = i_wr_data[15:0];
	assign new_ctrl = pct_ctrl_t'(i_wr_data[CTRL_W-1:0]);

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= pct_ctrl_t'(CTRL_RST);
		end else if (wr_ctrl) begin
			ctrl_q <= new_ctrl;
		end
	end

	// Timer A: down counter, reload on underflow.
	assign a_pwm_run = ctrl_q.start_a && (ctrl_q.mode_a == A_PWM);
	assign a_step    = (ctrl_q.mode_a == A_EVENT) ? ev_rise[0] : tick;
	assign a_stop    = wr_ctrl && ctrl_q.start_a && !new_ctrl.start_a
	                   && (ctrl_q.mode_a == A_PWM);
	assign pwm_next  = (cnt_a_q < high_a_q);

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_a_q    <= CNT_RST;
			reload_a_q <= RELOAD_RST;
		end else if (wr_a_cnt) begin
			reload_a_q <= wr_low;
			if (!ctrl_q.start_a) begin
				cnt_a_q <= wr_low;
			end
		end else if (ctrl_q.start_a && a_step) begin
			cnt_a_q <= (cnt_a_q == CNT_RST) ? reload_a_q : cnt_a_q - 16'h0001;
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			high_a_q <= HIGH_RST;
		end else if (i_wr_en && (i_addr == ADDR_A_HIGH)) begin
			high_a_q <= wr_low;
		end
	end

	// drive low on stop; a low output is left as it is.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pwm_q <= 1'b0;
		end else if (a_stop || (ctrl_q.mode_a != A_PWM)) begin
			pwm_q <= 1'b0;
		end else if (a_pwm_run && a_step) begin
			pwm_q <= pwm_next;
		end
	end
	assign o_pwm_output_pin = pwm_q;

	assign a_ev_mode  = wr_ctrl && (new_ctrl.mode_a == A_PWM) && (ctrl_q.mode_a != A_PWM);
	// only a high output raises the stop request.
	assign a_ev_stop  = a_stop && pwm_q;
	assign a_ev_fall  = a_pwm_run && a_step && pwm_q && !pwm_next && !a_stop;
	assign a_ev_under = ctrl_q.start_a && (ctrl_q.mode_a != A_PWM) && a_step
	                    && (cnt_a_q == CNT_RST) && !wr_a_cnt;

	// Timer B: down counter in timer and event modes, up counter in measurement.
	assign b_meas       = (ctrl_q.mode_b == B_MEAS);
	assign b_step       = (ctrl_q.mode_b == B_EVENT) ? ev_rise[1] : tick;
	assign b_edge       = ctrl_q.meas_width ? (ev_rise[1] | ev_fall[1]) : ev_rise[1];
	assign b_reload_now = ctrl_q.start_b && !b_meas && b_step && (cnt_b_q == CNT_RST)
	                      && !wr_b_cnt;

	// halted write loads the counter too.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_b_q    <= CNT_RST;
			reload_b_q <= RELOAD_RST;
		end else if (wr_b_cnt && !b_meas) begin
			reload_b_q <= wr_low;
			if (!ctrl_q.start_b) begin
				cnt_b_q <= wr_low;
			end
		end else if (ctrl_q.start_b && b_meas && b_edge) begin
			// capture without clearing the start-up value first.
			reload_b_q <= cnt_b_q;
			cnt_b_q    <= CNT_RST;
		end else if (ctrl_q.start_b && b_meas && tick) begin
			cnt_b_q <= cnt_b_q + 16'h0001;
		end else if (ctrl_q.start_b && !b_meas && b_step) begin
			cnt_b_q <= (cnt_b_q == CNT_RST) ? reload_b_q : cnt_b_q - 16'h0001;
		end
	end

	// The first edge after a start only primes the capture.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			first_q <= 1'b0;
		end else if (wr_ctrl && new_ctrl.start_b && !ctrl_q.start_b) begin
			first_q <= 1'b1;
		end else if (ctrl_q.start_b && b_meas && b_edge) begin
			first_q <= 1'b0;
		end
	end

	assign b_ev_sel  = wr_ctrl && ctrl_q.start_b && b_meas
	                   && (new_ctrl.meas_width != ctrl_q.meas_width);
	// no request on the priming edge.
	assign b_ev_edge = ctrl_q.start_b && b_meas && b_edge && !first_q;
	assign b_ev_ovf  = ctrl_q.start_b && b_meas && tick && !b_edge && (cnt_b_q == ALL_ONES);

	always_comb begin
		irq_set          = IRQ_RST;
		irq_set[IRQ_A]   = a_ev_mode | a_ev_stop | a_ev_fall | a_ev_under;
		irq_set[IRQ_B]   = b_reload_now | b_ev_sel | b_ev_edge | b_ev_ovf;
		irq_set[IRQ_OVF] = b_ev_ovf;
	end
	assign irq_clr = (i_wr_en && (i_addr == ADDR_STATUS)) ? i_wr_data[IRQ_W-1:0] : IRQ_RST;

	// A request arriving with a write-one-to-clear survives it.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= IRQ_RST;
		end else begin
			status_q <= (status_q & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= IRQ_RST;
		end else if (i_wr_en && (i_addr == ADDR_MASK)) begin
			mask_q <= i_wr_data[IRQ_W-1:0];
		end
	end
	assign o_irq = |(status_q & mask_q);

	// live counter read, all ones in the reload cycle.
	always_comb begin
		rd_d = 32'h00000000;
		unique case (i_addr)
			ADDR_CTRL:   rd_d[CTRL_W-1:0] = ctrl_q;
			ADDR_A_CNT:  rd_d[15:0] = cnt_a_q;
			ADDR_A_HIGH: rd_d[15:0] = high_a_q;
			ADDR_B_CNT:  rd_d[15:0] = b_meas ? reload_b_q
			                        : (b_reload_now ? ALL_ONES : cnt_b_q);
			ADDR_STATUS: rd_d[IRQ_W-1:0] = status_q;
			ADDR_MASK:   rd_d[IRQ_W-1:0] = mask_q;
			default:     rd_d = 32'h00000000;
		endcase
	end

	// Read data stand for the single cycle after the strobe.
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_q <= 32'h00000000;
		end else if (i_rd_en) begin
			rd_data_q <= rd_d;
		end else begin
			rd_data_q <= 32'h00000000;
		end
	end
	assign o_rd_data = rd_data_q;

	a_pwm_entry_irq: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		a_ev_mode |=> status_q[IRQ_A])
		else $error("PWM mode entry did not set timer A request.");

	a_pwm_stop_hold: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		a_stop ##1 (!wr_a_cnt && !wr_ctrl) |=> $stable(cnt_a_q))
		else $error("Timer A kept counting after stop.");

	a_stop_high_low: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		(a_stop && pwm_q) |=> (!o_pwm_output_pin && status_q[IRQ_A]))
		else $error("High PWM stop did not go low with request.");

	a_stop_low_quiet: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		(a_stop && !pwm_q && !status_q[IRQ_A] && new_ctrl.mode_a == A_PWM)
		|=> (!o_pwm_output_pin && !status_q[IRQ_A]))
		else $error("Low PWM stop changed output or request.");

	a_read_live: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		(i_rd_en && i_addr == ADDR_B_CNT && !b_meas && !b_reload_now)
		|=> (o_rd_data[15:0] == $past(cnt_b_q)))
		else $error("Timer B read did not return the counter.");

	a_read_reload_ones: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		(i_rd_en && i_addr == ADDR_B_CNT && b_reload_now) |=> (o_rd_data == 32'h0000FFFF))
		else $error("Reload cycle read was not all ones.");

	a_halted_write: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		(wr_b_cnt && !b_meas && !ctrl_q.start_b) |=> (cnt_b_q == $past(wr_low)))
		else $error("Halted write not seen in the counter.");

	a_meas_sel_irq: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		b_ev_sel |=> status_q[IRQ_B])
		else $error("Selection change did not set timer B request.");

	a_first_edge_quiet: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		(ctrl_q.start_b && b_meas && b_edge && first_q && !status_q[IRQ_B] && !wr_ctrl)
		|=> (!status_q[IRQ_B] && !first_q))
		else $error("First measurement edge raised a request.");

	a_overflow_flag: assert property (
		@(posedge i_clock) disable iff (!rst_n)
		b_ev_ovf |=> (status_q[IRQ_OVF] && status_q[IRQ_B] && cnt_b_q == CNT_RST))
		else $error("Measurement overflow not flagged.");

endmodule

/* File: pct_pkg.sv */
package pct_pkg;

	// Register byte offsets on the plain register port.
	localparam logic [4:0] ADDR_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_A_CNT  = 5'h04;
	localparam logic [4:0] ADDR_A_HIGH = 5'h08;
	localparam logic [4:0] ADDR_B_CNT  = 5'h0C;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	localparam logic [4:0] ADDR_MASK   = 5'h14;

	// Operating mode codes of the first timer.
	localparam logic [1:0] A_TIMER = 2'h0;
	localparam logic [1:0] A_EVENT = 2'h1;
	localparam logic [1:0] A_PWM   = 2'h3;

	// Operating mode codes of the second timer.
	localparam logic [1:0] B_TIMER = 2'h0;
	localparam logic [1:0] B_EVENT = 2'h1;
	localparam logic [1:0] B_MEAS  = 2'h2;

	// Control word layout, bit 0 first from the right.
	typedef struct packed {
		logic       meas_width;
		logic [1:0] mode_b;
		logic [1:0] mode_a;
		logic       start_b;
		logic       start_a;
	} pct_ctrl_t;

	localparam int         CTRL_W   = 7;
	localparam logic [6:0] CTRL_RST = 7'h00;

	// Status and mask bit positions.
	localparam int         IRQ_A   = 0;
	localparam int         IRQ_B   = 1;
	localparam int         IRQ_OVF = 2;
	localparam int         IRQ_W   = 3;
	localparam logic [2:0] IRQ_RST = 3'h0;

	localparam logic [15:0] ALL_ONES   = 16'hFFFF;
	localparam logic [15:0] RELOAD_RST = 16'hFFFF;
	localparam logic [15:0] HIGH_RST   = 16'h0000;
	localparam logic [15:0] CNT_RST    = 16'h0000;

	// Count source: one tick every PRESCALE system clocks.
	localparam int         PRESCALE = 4;
	localparam logic [1:0] DIV_LAST = 2'(PRESCALE - 1);

endpackage

/* File: pct_timer_tb_top.sv */
`timescale 1ns/10ps
module pct_timer_tb_top
	import pct_pkg::*;
;
	typedef struct packed {
		logic [4:0]  addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
	} pct_row_t;

	// Each row is written while halted and read straight back.
	localparam pct_row_t ROWS [5] = '{
		'{ADDR_B_CNT, 32'h0000_1234, 32'h0000_1234},
		'{ADDR_A_CNT, 32'h0000_0055, 32'h0000_0055},
		'{ADDR_MASK, 32'h0000_0007, 32'h0000_0007},
		'{5'h18, 32'h0000_FFFF, 32'h0000_0000},
		'{ADDR_STATUS, 32'h0000_0007, 32'h0000_0000}
	};

	logic        i_clock = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [4:0]  i_addr = 5'h00;
	logic [31:0] i_wr_data = 32'h0000_0000;
	logic        i_wr_en = 1'b0;
	logic        i_rd_en = 1'b0;
	logic [31:0] o_rd_data;
	logic        i_event_a = 1'b0;
	logic        i_event_b = 1'b0;
	logic        o_pwm_output_pin;
	logic        o_irq;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [31:0] d;
	logic [31:0] e;
	logic        seen;

	pct_timer DUT (
		.i_clock         (i_clock),
		.i_rst_n         (i_rst_n),
		.i_addr          (i_addr),
		.i_wr_data       (i_wr_data),
		.i_wr_en         (i_wr_en),
		.i_rd_en         (i_rd_en),
		.o_rd_data       (o_rd_data),
		.i_event_a       (i_event_a),
		.i_event_b       (i_event_b),
		.o_pwm_output_pin(o_pwm_output_pin),
		.o_irq           (o_irq)
	);

	always #20 i_clock = ~i_clock;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// A hung wait would otherwise stall the run; the whole plan needs about 500 cycles.
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_wr_data <= v;
		i_wr_en <= 1'b1;
		@(posedge i_clock);
		i_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_clock);
		i_rd_en <= 1'b0;
		@(negedge i_clock);
		v = o_rd_data;
	endtask

	task automatic do_reset();
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (20) @(posedge i_clock);
		i_rst_n <= 1'b1;
		repeat (4) @(posedge i_clock);
	endtask

	task automatic test_done(input string name);
		$display("test %s done", name);
	endtask

	initial begin
		do_reset();
		foreach (ROWS[i]) begin
			wr(ROWS[i].addr, ROWS[i].wdata);
			rd(ROWS[i].addr, d);
			chk_word(d, ROWS[i].rdata, "row readback");
		end
		test_done("register rows");

		// A pending request before the mid-run reset shows that reset really clears it.
		wr(ADDR_MASK, 32'h0000_0007);
		wr(ADDR_CTRL, 32'h0000_000C);
		@(negedge i_clock);
		chk_bit(o_irq, 1'b1, "irq before reset");
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		@(negedge i_clock);
		chk_bit(o_irq, 1'b0, "irq in reset");
		do_reset();
		rd(ADDR_CTRL, d);
		chk_word(d, 32'h0000_0000, "ctrl after reset");
		rd(ADDR_MASK, d);
		chk_word(d, 32'h0000_0000, "mask after reset");
		test_done("mid-run reset");
		// Selecting the pulse mode, from reset and from each other mode, raises the flag.
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_CTRL, 32'(i << 2));
			wr(ADDR_STATUS, 32'h0000_0007);
			wr(ADDR_CTRL, 32'h0000_000C);
			rd(ADDR_STATUS, d);
			chk_word(d, 32'h0000_0001, "flag on pwm entry");
		end
		test_done("mode entry");

		wr(ADDR_MASK, 32'h0000_0007);
		wr(ADDR_A_CNT, 32'h0000_0100);
		wr(ADDR_A_HIGH, 32'h0000_FFFF);
		wr(ADDR_CTRL, 32'h0000_000D);
		repeat (20) @(posedge i_clock);
		wr(ADDR_STATUS, 32'h0000_0007);
		@(negedge i_clock);
		chk_bit(o_pwm_output_pin, 1'b1, "pwm high");
		wr(ADDR_CTRL, 32'h0000_000C);
		@(negedge i_clock);
		chk_bit(o_pwm_output_pin, 1'b0, "pwm low on stop");
		chk_bit(o_irq, 1'b1, "irq on stop");
		rd(ADDR_A_CNT, e);
		repeat (20) @(posedge i_clock);
		rd(ADDR_A_CNT, d);
		chk_word(d, e, "counter frozen");
		wr(ADDR_A_HIGH, 32'h0000_0000);
		wr(ADDR_CTRL, 32'h0000_000D);
		repeat (20) @(posedge i_clock);
		wr(ADDR_STATUS, 32'h0000_0007);
		wr(ADDR_CTRL, 32'h0000_000C);
		repeat (8) @(posedge i_clock);
		@(negedge i_clock);
		chk_bit(o_pwm_output_pin, 1'b0, "pwm stays low");
		rd(ADDR_STATUS, d);
		chk_word(d, 32'h0000_0000, "no flag low stop");
		test_done("pwm stop");

		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_B_CNT, 32'h0000_0100);
		wr(ADDR_CTRL, 32'h0000_0002);
		repeat (8) @(posedge i_clock);
		rd(ADDR_B_CNT, e);
		repeat (38) @(posedge i_clock);
		rd(ADDR_B_CNT, d);
		// Forty clocks between the two strobes is exactly ten count ticks.
		chk_word(e - d, 32'h0000_000A, "live counter");
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_B_CNT, 32'h0000_0003);
		wr(ADDR_CTRL, 32'h0000_0002);
		seen = 1'b0;
		@(posedge i_clock);
		i_addr <= ADDR_B_CNT;
		i_rd_en <= 1'b1;
		repeat (40) begin
			@(negedge i_clock);
			if (o_rd_data === 32'h0000_FFFF) seen = 1'b1;
			chk_bit(o_rd_data <= 32'h3 || o_rd_data === 32'hFFFF, 1'b1, "read range");
		end
		@(posedge i_clock);
		i_rd_en <= 1'b0;
		chk_bit(seen, 1'b1, "all ones at reload");
		test_done("timer b reads");

		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_B_CNT, 32'h0000_FFF0);
		wr(ADDR_CTRL, 32'h0000_0020);
		wr(ADDR_CTRL, 32'h0000_0022);
		wr(ADDR_STATUS, 32'h0000_0007);
		repeat (100) @(posedge i_clock);
		rd(ADDR_STATUS, d);
		chk_word(d, 32'h0000_0006, "overflow before edge");
		wr(ADDR_STATUS, 32'h0000_0007);
		i_event_b <= 1'b1;
		repeat (12) @(posedge i_clock);
		rd(ADDR_STATUS, d);
		chk_word(d, 32'h0000_0000, "no flag first edge");
		@(posedge i_clock);
		i_event_b <= 1'b0;
		repeat (12) @(posedge i_clock);
		i_event_b <= 1'b1;
		repeat (12) @(posedge i_clock);
		rd(ADDR_STATUS, d);
		chk_word(d, 32'h0000_0002, "flag second edge");
		chk_bit(o_irq, 1'b1, "irq while unmasked");
		wr(ADDR_MASK, 32'h0000_0000);
		@(negedge i_clock);
		chk_bit(o_irq, 1'b0, "masked irq");
		wr(ADDR_STATUS, 32'h0000_0007);
		wr(ADDR_CTRL, 32'h0000_0062);
		rd(ADDR_STATUS, d);
		chk_word(d, 32'h0000_0002, "selection change");
		test_done("measurement");

		// Both timers in event mode; three rising pin edges count each down from five.
		wr(ADDR_CTRL, 32'h0000_0000);
		wr(ADDR_A_CNT, 32'h0000_0005);
		wr(ADDR_B_CNT, 32'h0000_0005);
		wr(ADDR_CTRL, 32'h0000_0017);
		repeat (3) begin
			i_event_a <= 1'b0;
			i_event_b <= 1'b0;
			repeat (4) @(posedge i_clock);
			i_event_a <= 1'b1;
			i_event_b <= 1'b1;
			repeat (4) @(posedge i_clock);
		end
		rd(ADDR_A_CNT, d);
		chk_word(d, 32'h0000_0002, "timer a event count");
		rd(ADDR_B_CNT, d);
		chk_word(d, 32'h0000_0002, "timer b event count");
		test_done("event counts");
		end_sim();
	end
endmodule
